// file: acs_consts.svh
// offsets, field positions, reset values and timing figures of the calibration sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_OFS_SETUP 8'h00
`define ACS_OFS_CHSEL 8'h04
`define ACS_OFS_CALCTL 8'h08
`define ACS_OFS_OFSH 8'h0c
`define ACS_OFS_OFSL 8'h10
`define ACS_OFS_GAINH 8'h14
`define ACS_OFS_GAINL 8'h18
`define ACS_OFS_STS 8'h1c
`define ACS_OFS_MASK 8'h20
`define ACS_CTL_START 0
`define ACS_CTL_KIND 1
`define ACS_CTL_AVG_LO 4
`define ACS_CTL_BUSY 7
`define ACS_SET_ACQ_LO 2
`define ACS_SET_DIV_LO 4
`define ACS_SET_EXTREF 6
`define ACS_CH_INT_GND 4'hb
`define ACS_CH_INT_REF 4'hc
`define ACS_CAL_CONV_CYCLES 14
`define ACS_CAL_BASE_CLKS 16
`define ACS_SETUP_RST 8'h00
`define ACS_COEFF_RST 14'h2000
`endif

// file: acs_pkg.sv
// types of the calibration sequencer
package acs_pkg;
   typedef enum logic [1:0] {ACS_SRC_EXT, ACS_SRC_GND, ACS_SRC_REF} acs_src_t;
   typedef enum logic {ACS_IDLE, ACS_RUN} acs_phase_t;
   typedef struct packed {
      acs_phase_t phase;
      logic [7:0] setup;
      logic [3:0] chsel;
      logic kind;
      logic [1:0] avg;
      logic [13:0] ofs;
      logic [13:0] gain;
      logic [1:0] sts;
      logic [1:0] mask;
      logic [4:0] div;
      logic tick;
      logic [14:0] left;
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic [13:0] s1;
      logic [13:0] s2;
      logic [13:0] s3;
      logic [13:0] res;
   } acs_state_t;
endpackage : acs_pkg

// file: acs_cal_seq.sv
// calibration sequencer: apb registers, cycle timer, coefficient capture
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_cal_seq import acs_pkg::*; #(
   parameter int RES_W = 14 // coefficient width
) (
   input wire logic MCLK, // core clock, 250 MHz
   input wire logic RST_N, // asynchronous reset, active low
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [RES_W-1:0] CAL_RESULT, // measured coefficient from converter core
   output logic CAL_ACTIVE, // calibration cycle in progress
   output logic CAL_KIND, // 0 offset, 1 gain
   output logic [1:0] CAL_SRC, // calibration source, acs_src_t
   output logic [3:0] CAL_CHANNEL, // selected input channel
   output logic EXT_REF, // external reference mode
   output logic CONV_STROBE, // one converter clock tick while calibrating
   output logic IRQ // level interrupt
);
   // the logic is written for the documented 14-bit split only
   if (RES_W != 14) begin : g_chk
      $error("acs_cal_seq: RES_W must be 14");
   end

   // averaging field decode; the four counts are a small fixed table
   function automatic logic [5:0] avg_count(input logic [1:0] f);
      case (f)
         2'h0: avg_count = 6'h0f;
         2'h1: avg_count = 6'h01;
         2'h2: avg_count = 6'h1f;
         default: avg_count = 6'h3f;
      endcase
   endfunction : avg_count

   // converter clock ticks of one cycle, at most 14*63*20 so 15 bits suffice
   function automatic logic [14:0] cycle_ticks(input logic [1:0] f, input logic [1:0] acq);
      int t;
      t = `ACS_CAL_CONV_CYCLES * int'(avg_count(f)) * (`ACS_CAL_BASE_CLKS + int'(acq) + 1);
      cycle_ticks = t[14:0];
   endfunction : cycle_ticks

   // core clocks per converter clock: 00 gives 16, else 2, 4, 8
   function automatic logic [4:0] div_count(input logic [1:0] f);
      case (f)
         2'h0: div_count = 5'h10;
         2'h1: div_count = 5'h02;
         2'h2: div_count = 5'h04;
         default: div_count = 5'h08;
      endcase
   endfunction : div_count

   acs_state_t st_ff; // all state
   acs_state_t nxt_st; // its next value
   logic acc; // access phase of a transfer
   logic done; // last tick of the cycle
   logic start; // accepted start request
   logic [31:0] rd; // read mux
   logic hit; // mapped address

   // register mux and next state
   always_comb begin
      nxt_st = st_ff;
      acc = PSEL && PENABLE;
      done = (st_ff.phase == ACS_RUN) && st_ff.tick && (st_ff.left == 15'h0001);
      start = 1'b0;
      hit = 1'b1;
      rd = 32'h0;
      case (PADDR)
         `ACS_OFS_SETUP: rd = {24'h0, st_ff.setup};
         `ACS_OFS_CHSEL: rd = {28'h0, st_ff.chsel};
         `ACS_OFS_CALCTL: rd = {24'h0, st_ff.phase == ACS_RUN, 1'b0, st_ff.avg,
            2'h0, st_ff.kind, 1'b0};
         `ACS_OFS_OFSH: rd = {26'h0, st_ff.ofs[13:8]};
         `ACS_OFS_OFSL: rd = {24'h0, st_ff.ofs[7:0]};
         `ACS_OFS_GAINH: rd = {26'h0, st_ff.gain[13:8]};
         `ACS_OFS_GAINL: rd = {24'h0, st_ff.gain[7:0]};
         `ACS_OFS_STS: rd = {30'h0, st_ff.sts};
         `ACS_OFS_MASK: rd = {30'h0, st_ff.mask};
         default: hit = 1'b0;
      endcase
      // three-stage input sync; a new result counts once stages two and three agree
      nxt_st.s1 = CAL_RESULT;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      if (st_ff.s2 == st_ff.s3) begin
         nxt_st.res = st_ff.s3;
      end
      // converter clock divider; runs free so the tick phase is independent of the start
      nxt_st.tick = 1'b0;
      if (st_ff.div <= 5'h01) begin
         nxt_st.div = div_count(st_ff.setup[`ACS_SET_DIV_LO +: 2]);
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.div = st_ff.div - 5'h01;
      end
      // one wait state: first access cycle loads read data, second completes
      nxt_st.rdy = 1'b0;
      nxt_st.err = 1'b0;
      if (acc && !st_ff.rdy) begin
         nxt_st.rdy = 1'b1;
         nxt_st.err = !hit;
         nxt_st.rdata = PWRITE ? 32'h0 : rd;
      end
      // writes take effect at the completing edge
      if (acc && st_ff.rdy && PWRITE && hit) begin
         case (PADDR)
            `ACS_OFS_SETUP: nxt_st.setup = PWDATA[7:0];
            `ACS_OFS_CHSEL: nxt_st.chsel = PWDATA[3:0];
            `ACS_OFS_CALCTL: begin
               // a start during a cycle is ignored so the running cycle stays whole
               if (PWDATA[`ACS_CTL_START] && st_ff.phase == ACS_IDLE) begin
                  start = 1'b1;
                  nxt_st.kind = PWDATA[`ACS_CTL_KIND];
                  nxt_st.avg = PWDATA[`ACS_CTL_AVG_LO +: 2];
               end
            end
            `ACS_OFS_OFSH: nxt_st.ofs[13:8] = PWDATA[5:0];
            `ACS_OFS_OFSL: nxt_st.ofs[7:0] = PWDATA[7:0];
            `ACS_OFS_GAINH: nxt_st.gain[13:8] = PWDATA[5:0];
            `ACS_OFS_GAINL: nxt_st.gain[7:0] = PWDATA[7:0];
            `ACS_OFS_MASK: nxt_st.mask = PWDATA[1:0];
            default: nxt_st.sts = st_ff.sts & ~PWDATA[1:0]; // write one to clear
         endcase
      end
      // calibration cycle sequencer
      case (st_ff.phase)
         ACS_IDLE: begin
            if (start) begin
               nxt_st.phase = ACS_RUN;
               nxt_st.left = cycle_ticks(PWDATA[`ACS_CTL_AVG_LO +: 2],
                  st_ff.setup[`ACS_SET_ACQ_LO +: 2]);
            end
         end
         ACS_RUN: begin
            if (st_ff.tick) begin
               nxt_st.left = st_ff.left - 15'h0001;
            end
            if (done) begin
               nxt_st.phase = ACS_IDLE;
               if (st_ff.kind) begin
                  nxt_st.gain = st_ff.res;
               end else begin
                  nxt_st.ofs = st_ff.res;
               end
               // set wins over a clear in the same cycle
               nxt_st.sts[st_ff.kind] = 1'b1;
            end
         end
         default: nxt_st.phase = ACS_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff <= '{phase: ACS_IDLE, setup: `ACS_SETUP_RST, ofs: `ACS_COEFF_RST,
            gain: `ACS_COEFF_RST, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // source: internal ground or reference only on the matching kind, else the channel
   always_comb begin
      if (!st_ff.kind && st_ff.chsel == `ACS_CH_INT_GND) begin
         CAL_SRC = ACS_SRC_GND;
      end else if (st_ff.kind && st_ff.chsel == `ACS_CH_INT_REF) begin
         CAL_SRC = ACS_SRC_REF;
      end else begin
         CAL_SRC = ACS_SRC_EXT;
      end
   end

   // outputs
   assign PRDATA = st_ff.rdata;
   assign PREADY = st_ff.rdy;
   assign PSLVERR = st_ff.err;
   assign CAL_ACTIVE = (st_ff.phase == ACS_RUN);
   assign CAL_KIND = st_ff.kind;
   assign CAL_CHANNEL = st_ff.chsel;
   assign EXT_REF = st_ff.setup[`ACS_SET_EXTREF];
   assign CONV_STROBE = st_ff.tick && CAL_ACTIVE;
   assign IRQ = |(st_ff.sts & st_ff.mask);

   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   logic [14:0] run_cnt; // converter ticks seen in the current cycle
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         run_cnt <= 15'h0;
      end else if (start) begin
         run_cnt <= 15'h0;
      end else if (CONV_STROBE) begin
         run_cnt <= run_cnt + 15'h0001;
      end
   end

   mode_select_a: assert property (start |=> CAL_KIND == $past(PWDATA[1]))
      else $error("kind bit not taken on start");
   int_ground_a: assert property (CAL_ACTIVE && !CAL_KIND && CAL_CHANNEL == 4'hb
      |-> CAL_SRC == ACS_SRC_GND)
      else $error("offset on 1011 not on internal ground");
   int_ref_a: assert property (CAL_ACTIVE && CAL_KIND && CAL_CHANNEL == 4'hc
      |-> CAL_SRC == ACS_SRC_REF)
      else $error("gain on 1100 not on internal reference");
   ext_input_a: assert property (CAL_CHANNEL < 4'hb |-> CAL_SRC == ACS_SRC_EXT)
      else $error("external channel not used");
   cycle_length_a: assert property ($fell(CAL_ACTIVE) |->
      run_cnt == cycle_ticks(st_ff.avg, st_ff.setup[3:2]))
      else $error("cycle length wrong");
   busy_start_a: assert property (start |=> CAL_ACTIVE [*8])
      else $error("busy not held after start");
   busy_bit_a: assert property (PREADY && PADDR == 8'h08 && !$past(PWRITE)
      |-> PRDATA[7] == $past(CAL_ACTIVE))
      else $error("busy bit wrong on read");
   coeff_high_a: assert property (PREADY && PADDR == 8'h0c |-> PRDATA[31:6] == 26'h0)
      else $error("offset high part wider than six bits");
   coeff_update_a: assert property ($fell(CAL_ACTIVE) && !CAL_KIND
      |-> st_ff.ofs == $past(st_ff.res))
      else $error("offset not updated at end");
   cov_offset_c: cover property (start ##1 !CAL_KIND);
   cov_gain_c: cover property ($fell(CAL_ACTIVE) && CAL_KIND);
   cov_irq_c: cover property ($rose(IRQ));
endmodule : acs_cal_seq

// file: acs_core_model.sv
// converter core model that answers calibration measurements
`timescale 1ns/1ps
module acs_core_model import acs_pkg::*; (
   input wire logic MCLK, // core clock
   input wire logic RST_N, // reset, active low
   input wire logic CAL_ACTIVE, // cycle in progress
   input wire logic CAL_KIND, // 0 offset, 1 gain
   input wire logic [1:0] CAL_SRC, // chosen source
   input wire logic [3:0] CAL_CHANNEL, // chosen input
   output logic [13:0] CAL_RESULT // measured coefficient
);
   // idle output toggles every cycle so stale data never looks valid
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         CAL_RESULT <= 14'h0000;
      end else if (!CAL_ACTIVE) begin
         CAL_RESULT <= ~CAL_RESULT;
      end else if (CAL_SRC == ACS_SRC_GND) begin
         CAL_RESULT <= 14'h0155;
      end else if (CAL_SRC == ACS_SRC_REF) begin
         CAL_RESULT <= 14'h2aaa;
      end else begin
         CAL_RESULT <= {1'b1, CAL_KIND, 8'h5a, CAL_CHANNEL};
      end
   end
endmodule : acs_core_model

// file: acs_cal_seq_tb.sv
// self-checking bench: apb register access and calibration runs
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_cal_seq_tb import acs_pkg::*; ;
   logic mclk = 1'b0; // core clock
   logic rst_n = 1'b0; // reset, active low
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, cal_active, cal_kind, ext_ref, conv_strobe, irq;
   logic [1:0] cal_src;
   logic [3:0] cal_channel;
   logic [13:0] cal_result;
   int fail_count = 0, n_compared = 0, n_ticks = 0, t0, j;
   // case tables: device offset, device gain, system offset, system gain
   // every case calibrates at divide 16 with four acquisition clocks; system cases add ext ref
   logic [7:0] set_tab [4] = '{8'h0c, 8'h0c, 8'h4c, 8'h4c};
   logic [1:0] avg_tab [4] = '{2'b00, 2'b01, 2'b01, 2'b01};
   int n_tab [4] = '{4200, 280, 280, 280};
   logic [3:0] ch_tab [4] = '{4'hb, 4'hc, 4'h0, 4'h1};
   logic [1:0] src_tab [4] = '{ACS_SRC_GND, ACS_SRC_REF, ACS_SRC_EXT, ACS_SRC_EXT};
   logic [13:0] res_tab [4] = '{14'h0155, 14'h2aaa, 14'h25a0, 14'h35a1};
   always #2 mclk = ~mclk;
   // count converter ticks so the cycle length can be judged
   always @(posedge mclk) if (conv_strobe === 1'b1) n_ticks <= n_ticks + 1;
   acs_cal_seq u_acs_cal_seq (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CAL_RESULT(cal_result), .CAL_ACTIVE(cal_active),
      .CAL_KIND(cal_kind), .CAL_SRC(cal_src), .CAL_CHANNEL(cal_channel),
      .EXT_REF(ext_ref), .CONV_STROBE(conv_strobe), .IRQ(irq));
   acs_core_model u_acs_core_model (.MCLK(mclk), .RST_N(rst_n), .CAL_ACTIVE(cal_active),
      .CAL_KIND(cal_kind), .CAL_SRC(cal_src), .CAL_CHANNEL(cal_channel),
      .CAL_RESULT(cal_result));
   // prints the counts and the verdict, then ends the run
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   // one comparison, four-state exact
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         fail_count++;
         wrap_up();
      end
   endtask : apb
   // main sequence: reset values, unmapped access, four calibration runs
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, `ACS_OFS_OFSH, 32'h0);
      check(rd, 32'h20);
      apb(1'b0, `ACS_OFS_GAINL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check({rd[30:0], er}, 32'h1); // unmapped read gives zero and an error
      apb(1'b1, `ACS_OFS_MASK, 32'h3);
      // offset always runs before gain, both for device and system cases
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `ACS_OFS_SETUP, {24'h0, set_tab[i]});
         apb(1'b1, `ACS_OFS_CHSEL, {28'h0, ch_tab[i]});
         check(ext_ref, set_tab[i][6]);
         t0 = n_ticks;
         apb(1'b1, `ACS_OFS_CALCTL, {26'h0, avg_tab[i], 2'b00, i[0], 1'b1});
         @(posedge mclk);
         check({cal_active, cal_kind, cal_src, cal_channel},
            {1'b1, i[0], src_tab[i], ch_tab[i]});
         // a second start while busy must not restart the cycle
         apb(1'b1, `ACS_OFS_CALCTL, {26'h0, avg_tab[i], 2'b00, i[0], 1'b1});
         apb(1'b0, `ACS_OFS_CALCTL, 32'h0);
         check(rd[7], 1'b1);
         // a poll read takes four clocks and a tick sixteen, so four reads a tick plus slack
         for (j = 0; j < n_tab[i] * 4 + 64 && rd[7] !== 1'b0; j++) begin
            apb(1'b0, `ACS_OFS_CALCTL, 32'h0);
         end
         if (rd[7] !== 1'b0) begin
            fail_count++;
            wrap_up();
         end
         check(n_ticks - t0, n_tab[i]);
         apb(1'b0, i[0] ? `ACS_OFS_GAINH : `ACS_OFS_OFSH, 32'h0);
         check(rd, {26'h0, res_tab[i][13:8]});
         apb(1'b0, i[0] ? `ACS_OFS_GAINL : `ACS_OFS_OFSL, 32'h0);
         check(rd, {24'h0, res_tab[i][7:0]});
         apb(1'b0, `ACS_OFS_STS, 32'h0);
         check({rd[30:0], irq}, {29'h0, i[0], ~i[0], 1'b1}); // done flag raises interrupt
         apb(1'b1, `ACS_OFS_MASK, 32'h0);
         repeat (2) @(posedge mclk);
         check(irq, 1'b0); // masked status keeps interrupt low
         apb(1'b1, `ACS_OFS_MASK, 32'h3);
         apb(1'b1, `ACS_OFS_STS, 32'h3);
         repeat (2) @(posedge mclk);
         check(irq, 1'b0); // write-one clear drops interrupt
      end
      wrap_up();
   end
endmodule : acs_cal_seq_tb
